// [logic/tkec_top.sv]
// Touch-key scan, event, interrupt and sleep control
//
// Overview of operation
// - Without auto-release, interrupt stays low until both status bytes are read.
// - With auto-release, reads or the programmed 10-200 ms timeout release it.
// - Sweep rate zero switches spread-spectrum modulation off.
// - Amplitude setting bounds the scan frequency deviation.
// - Limit disabled: every pressed key is reported.
// - Limit enabled: at most one, two or three keys held together.
// - Single mode: one interrupt per press and per release.
// - Repeat mode: repeated interrupts while held, one on release.
// - Repeat: first-repeat delay, then repeat interval, in milliseconds.
// - Baselines of keys not reported pressed recalibrate every programmed number of scan rounds.
// - Sustained negative drift beyond threshold forces that key's recalibration.
// - Programmed number of samples per key are averaged.
// - Key sampling time is sample time times sample count.
// - Programmed round delay in milliseconds separates scan rounds.
// - Auto sleep after the programmed idle time without key activity.
// - In sleep, only wake-enabled keys reaching wake threshold wake.
`timescale 1ns/10ps
module tkec_top
  import tkec_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEFAULT
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  input  wire logic               i_reg_rd,
  input  wire logic [7:0]         i_reg_addr,
  output logic [7:0]              o_reg_rdata,
  output logic                    o_reg_rvalid,
  output logic                    o_irq_out_n,
  input  wire logic               i_auto_release_en,
  input  wire logic [7:0]         i_auto_release_ms,
  input  wire logic               i_int_mode,
  input  wire logic [15:0]        i_first_repeat_ms,
  input  wire logic [15:0]        i_repeat_ms,
  input  wire logic               i_limit_en,
  input  wire logic [1:0]         i_concurrent_key_limit,
  input  wire logic [3:0]         i_ss_sweep_rate,
  input  wire logic [5:0]         i_ss_amplitude,
  output logic                    o_ss_active,
  output logic signed [7:0]       o_ss_offset,
  input  wire logic [7:0]         i_recal_cycle_count,
  input  wire logic [15:0]        i_negative_drift_threshold,
  input  wire logic [7:0]         i_forced_recal_threshold,
  input  wire logic [15:0]        i_touch_threshold,
  input  wire logic [2:0]         i_samples_per_key_log2,
  input  wire logic [7:0]         i_sample_cycles,
  output logic                    o_sample_start,
  output logic [KEY_W-1:0]        o_scan_key,
  input  wire logic [VAL_W-1:0]   i_raw_value,
  input  wire logic [7:0]         i_round_delay_ms,
  input  wire logic               i_auto_sleep_en,
  input  wire logic [15:0]        i_sleep_idle_ms,
  input  wire logic [15:0]        i_wake_enable,
  input  wire logic [15:0]        i_wake_threshold,
  output logic                    o_sleep
);

  typedef struct packed {
    tkec_scan_e                          scan_st;
    logic [KEY_W-1:0]                    key;
    logic [7:0]                          smp_cnt;
    logic [7:0]                          tim;
    logic [ACC_W-1:0]                    acc;
    logic [NUM_KEYS-1:0][VAL_W-1:0]      base;
    logic [NUM_KEYS-1:0][7:0]            negc;
    logic                                calibrated;
    logic                                recal_round;
    logic [7:0]                          round_cnt;
    logic [7:0]                          delay_ms;
    logic [15:0]                         status;
    logic                                start;
    logic                                irq_n;
    logic                                rd_lo;
    logic                                rd_hi;
    logic [7:0]                          auto_ms;
    logic [15:0]                         rep_ms;
    logic                                rep_first;
    logic [15:0]                         idle_ms;
    logic                                sleep;
    logic [7:0]                          rdata;
    logic                                rvalid;
  } tkec_top_s;

  tkec_top_s          s;
  tkec_top_s          next_s;
  logic               ms_tick;
  logic [VAL_W-1:0]   avg;
  logic signed [16:0] delta;
  logic signed [16:0] neg_mag;
  logic               pressed;
  logic               neg_drift;
  logic               wake_hit;
  logic               new_bit;
  logic               key_event;
  logic               rep_event;
  logic               any_event;
  logic [1:0]         limit;
  logic [7:0]         auto_lim;
  logic [8:0]         smp_total;
  logic [7:0]         smp_time;

  tkec_ms_tick #(
    .MS_CYCLES (MS_CYCLES)
  ) u_ms_tick (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .o_tick    (ms_tick)
  );

  tkec_spread u_spread (
    .i_ref_clk       (i_ref_clk),
    .i_rst           (i_rst),
    .i_ss_sweep_rate (i_ss_sweep_rate),
    .i_ss_amplitude  (i_ss_amplitude),
    .o_ss_active     (o_ss_active),
    .o_ss_offset     (o_ss_offset)
  );

  always_comb begin
    next_s        = s;
    next_s.start  = 1'b0;
    next_s.rvalid = 1'b0;
    key_event     = 1'b0;
    rep_event     = 1'b0;
    new_bit       = 1'b0;

    avg       = VAL_W'(s.acc >> i_samples_per_key_log2);
    delta     = $signed({1'b0, avg}) - $signed({1'b0, s.base[s.key]});
    neg_mag   = -delta;
    pressed   = delta > $signed({1'b0, i_touch_threshold});
    neg_drift = delta[16] &&
                (neg_mag > $signed({1'b0, i_negative_drift_threshold}));
    wake_hit  = i_wake_enable[s.key] &&
                (delta >= $signed({1'b0, i_wake_threshold}));
    limit     = (i_concurrent_key_limit == 2'h0) ? LIMIT_ONE_KEY
                                                 : i_concurrent_key_limit;
    smp_total = 9'(9'h001 << i_samples_per_key_log2);
    smp_time  = (i_sample_cycles == 8'h00) ? 8'h01 : i_sample_cycles;

    // Scan sequencer
    case (s.scan_st)
      SC_START: begin
        next_s.start   = 1'b1;
        next_s.tim     = 8'h00;
        next_s.scan_st = SC_SAMPLE;
      end
      SC_SAMPLE: begin
        next_s.tim = s.tim + 8'h01;
        if (s.tim + 8'h01 >= smp_time) begin
          next_s.acc     = s.acc + ACC_W'(i_raw_value);
          next_s.smp_cnt = s.smp_cnt + 8'h01;
          if ({1'b0, s.smp_cnt} + 9'h001 >= smp_total) begin
            next_s.scan_st = SC_EVAL;
          end else begin
            next_s.scan_st = SC_START;
          end
        end
      end
      SC_EVAL: begin
        next_s.acc     = '0;
        next_s.smp_cnt = 8'h00;
        if (!s.calibrated) begin
          next_s.base[s.key] = avg;
        end else if (s.sleep) begin
          if (wake_hit) begin
            next_s.sleep   = 1'b0;
            next_s.idle_ms = 16'h0000;
          end
        end else begin
          new_bit = pressed;
          if (pressed && !s.status[s.key] && i_limit_en &&
              (tkec_count_keys(s.status) >= {3'h0, limit})) begin
            new_bit = 1'b0;
          end
          next_s.status[s.key] = new_bit;
          key_event = new_bit != s.status[s.key];
          if (neg_drift) begin
            if (s.negc[s.key] + 8'h01 >= i_forced_recal_threshold) begin
              next_s.base[s.key] = avg;
              next_s.negc[s.key] = 8'h00;
            end else begin
              next_s.negc[s.key] = s.negc[s.key] + 8'h01;
            end
          end else begin
            next_s.negc[s.key] = 8'h00;
            if (s.recal_round && !new_bit) begin
              next_s.base[s.key] = avg;
            end
          end
        end
        if (s.key == KEY_W'(NUM_KEYS - 1)) begin
          next_s.key        = '0;
          next_s.calibrated = 1'b1;
          next_s.delay_ms   = 8'h00;
          if (s.round_cnt + 8'h01 >= i_recal_cycle_count) begin
            next_s.round_cnt   = 8'h00;
            next_s.recal_round = 1'b1;
          end else begin
            next_s.round_cnt   = s.round_cnt + 8'h01;
            next_s.recal_round = 1'b0;
          end
          if (i_round_delay_ms == 8'h00) begin
            next_s.scan_st = SC_START;
          end else begin
            next_s.scan_st = SC_ROUND_WAIT;
          end
        end else begin
          next_s.key     = s.key + 1'b1;
          next_s.scan_st = SC_START;
        end
      end
      SC_ROUND_WAIT: begin
        if (ms_tick) begin
          next_s.delay_ms = s.delay_ms + 8'h01;
          if (s.delay_ms + 8'h01 >= i_round_delay_ms) begin
            next_s.scan_st = SC_START;
          end
        end
      end
      default: begin
        next_s.scan_st = SC_START;
      end
    endcase

    // Auto-repeat while any key is held
    if (key_event || (next_s.status == 16'h0000) ||
        (i_int_mode != INT_MODE_REPEAT)) begin
      next_s.rep_ms    = 16'h0000;
      next_s.rep_first = 1'b1;
    end else if (ms_tick) begin
      next_s.rep_ms = tkec_inc16(s.rep_ms);
      if (s.rep_first && (tkec_inc16(s.rep_ms) >= i_first_repeat_ms)) begin
        rep_event        = 1'b1;
        next_s.rep_ms    = 16'h0000;
        next_s.rep_first = 1'b0;
      end else if (!s.rep_first &&
                   (tkec_inc16(s.rep_ms) >= i_repeat_ms)) begin
        rep_event     = 1'b1;
        next_s.rep_ms = 16'h0000;
      end
    end
    any_event = key_event || rep_event;

    // Status register reads
    if (i_reg_rd) begin
      next_s.rvalid = 1'b1;
      case (i_reg_addr)
        KEY_STATUS_LOW_ADDR:  next_s.rdata = s.status[7:0];
        KEY_STATUS_HIGH_ADDR: next_s.rdata = s.status[15:8];
        default:              next_s.rdata = UNMAPPED_READ_VALUE;
      endcase
    end

    // Interrupt line; a new event wins over a release in the same cycle
    auto_lim = (i_auto_release_ms < AUTO_REL_MIN_MS) ? AUTO_REL_MIN_MS :
               (i_auto_release_ms > AUTO_REL_MAX_MS) ? AUTO_REL_MAX_MS :
               i_auto_release_ms;
    if (any_event) begin
      next_s.irq_n   = 1'b0;
      next_s.rd_lo   = 1'b0;
      next_s.rd_hi   = 1'b0;
      next_s.auto_ms = 8'h00;
    end else if (!s.irq_n) begin
      if (i_reg_rd && (i_reg_addr == KEY_STATUS_LOW_ADDR)) begin
        next_s.rd_lo = 1'b1;
      end
      if (i_reg_rd && (i_reg_addr == KEY_STATUS_HIGH_ADDR)) begin
        next_s.rd_hi = 1'b1;
      end
      if (ms_tick) begin
        next_s.auto_ms = s.auto_ms + 8'h01;
      end
      if (next_s.rd_lo && next_s.rd_hi) begin
        next_s.irq_n = 1'b1;
        next_s.rd_lo = 1'b0;
        next_s.rd_hi = 1'b0;
      end else if (i_auto_release_en && ms_tick &&
                   (s.auto_ms + 8'h01 >= auto_lim)) begin
        next_s.irq_n = 1'b1;
        next_s.rd_lo = 1'b0;
        next_s.rd_hi = 1'b0;
      end
    end

    // Idle tracking toward sleep
    if (any_event || (s.status != 16'h0000) || s.sleep ||
        !i_auto_sleep_en) begin
      if (!s.sleep) begin
        next_s.idle_ms = 16'h0000;
      end
    end else if (ms_tick) begin
      next_s.idle_ms = tkec_inc16(s.idle_ms);
      if (tkec_inc16(s.idle_ms) >= i_sleep_idle_ms) begin
        next_s.sleep = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s           <= '0;
      s.scan_st   <= SC_START;
      s.irq_n     <= 1'b1;
      s.rep_first <= 1'b1;
      s.rdata     <= KEY_STATUS_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign o_reg_rdata    = s.rdata;
  assign o_reg_rvalid   = s.rvalid;
  assign o_irq_out_n    = s.irq_n;
  assign o_sample_start = s.start;
  assign o_scan_key     = s.key;
  assign o_sleep        = s.sleep;

endmodule : tkec_top

// [inc/tkec_pkg.sv]
// Shared constants, types and helpers of the touch-key event control block
package tkec_pkg;

  localparam int NUM_KEYS = 16;
  localparam int KEY_W    = 4;
  localparam int VAL_W    = 16;
  localparam int ACC_W    = 24;

  localparam logic [7:0] KEY_STATUS_LOW_ADDR  = 8'h02;
  localparam logic [7:0] KEY_STATUS_HIGH_ADDR = 8'h03;
  localparam logic [7:0] KEY_STATUS_RESET     = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE  = 8'h00;

  localparam int CLK_PERIOD_PS     = 4000;
  localparam int MS_PS             = 1000000000;
  localparam int MS_CYCLES_DEFAULT = MS_PS / CLK_PERIOD_PS;
  localparam int MS_CNT_W          = 18;

  localparam logic [7:0] AUTO_REL_MIN_MS = 8'h0A;
  localparam logic [7:0] AUTO_REL_MAX_MS = 8'hC8;

  localparam logic       INT_MODE_SINGLE = 1'b0;
  localparam logic       INT_MODE_REPEAT = 1'b1;
  localparam logic [1:0] LIMIT_ONE_KEY   = 2'h1;

  localparam logic [3:0] SS_RATE_OFF = 4'h0;

  typedef enum {
    SC_START,
    SC_SAMPLE,
    SC_EVAL,
    SC_ROUND_WAIT
  } tkec_scan_e;

  // Number of keys set in a status word
  function automatic logic [4:0] tkec_count_keys(input logic [15:0] keys);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < NUM_KEYS; i++) begin
      n = n + {4'h0, keys[i]};
    end
    return n;
  endfunction : tkec_count_keys

  // Saturating step of a millisecond counter
  function automatic logic [15:0] tkec_inc16(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction : tkec_inc16

endpackage : tkec_pkg

// [logic/tkec_ms_tick.sv]
// Millisecond tick generator
`timescale 1ns/10ps
module tkec_ms_tick
  import tkec_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEFAULT
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  output logic      o_tick
);

  typedef struct packed {
    logic [MS_CNT_W-1:0] cnt;
    logic                tick;
  } tkec_tick_s;

  tkec_tick_s s;
  tkec_tick_s next_s;

  always_comb begin
    next_s      = s;
    next_s.tick = 1'b0;
    if (s.cnt == MS_CNT_W'(MS_CYCLES - 1)) begin
      next_s.cnt  = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_tick = s.tick;

endmodule : tkec_ms_tick

// [logic/tkec_spread.sv]
// Triangle spread-spectrum offset for the scan clock
`timescale 1ns/10ps
module tkec_spread
  import tkec_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  input  wire logic [3:0]        i_ss_sweep_rate,
  input  wire logic [5:0]        i_ss_amplitude,
  output logic                   o_ss_active,
  output logic signed [7:0]      o_ss_offset
);

  typedef struct packed {
    logic [3:0]        prescale;
    logic signed [7:0] offset;
    logic              up;
    logic              active;
  } tkec_ss_s;

  tkec_ss_s          s;
  tkec_ss_s          next_s;
  logic signed [7:0] amp;

  always_comb begin
    next_s = s;
    amp    = $signed({2'b00, i_ss_amplitude});
    if (i_ss_sweep_rate == SS_RATE_OFF) begin
      next_s = '0;
    end else begin
      next_s.active = 1'b1;
      if (s.prescale >= i_ss_sweep_rate) begin
        next_s.prescale = 4'h0;
        // Swing bounded by the amplitude setting
        if (s.up) begin
          if (s.offset >= amp) begin
            next_s.up     = 1'b0;
            next_s.offset = s.offset - 8'sh01;
          end else begin
            next_s.offset = s.offset + 8'sh01;
          end
        end else begin
          if (s.offset <= -amp) begin
            next_s.up     = 1'b1;
            next_s.offset = s.offset + 8'sh01;
          end else begin
            next_s.offset = s.offset - 8'sh01;
          end
        end
      end else begin
        next_s.prescale = s.prescale + 4'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_ss_active = s.active;
  assign o_ss_offset = s.offset;

endmodule : tkec_spread

// [dv/tkec_top_props.sv]
// Property checker bound to the touch-key event control top
`timescale 1ns/10ps
module tkec_top_props
  import tkec_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEFAULT
) (
  input wire logic              i_ref_clk,
  input wire logic              i_rst,
  input wire logic              i_reg_rd,
  input wire logic [7:0]        i_reg_addr,
  input wire logic [7:0]        o_reg_rdata,
  input wire logic              o_reg_rvalid,
  input wire logic              o_irq_out_n,
  input wire logic              i_auto_release_en,
  input wire logic [7:0]        i_auto_release_ms,
  input wire logic [3:0]        i_ss_sweep_rate,
  input wire logic [5:0]        i_ss_amplitude,
  input wire logic              o_ss_active,
  input wire logic signed [7:0] o_ss_offset,
  input wire logic [7:0]        i_sample_cycles,
  input wire logic              o_sample_start,
  input wire logic [KEY_W-1:0]  o_scan_key,
  input wire logic              o_sleep
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  int         low_cnt;
  logic [7:0] rel_ms;
  logic [7:0] gap_cnt;

  assign rel_ms = (i_auto_release_ms < AUTO_REL_MIN_MS) ? AUTO_REL_MIN_MS :
                  (i_auto_release_ms > AUTO_REL_MAX_MS) ? AUTO_REL_MAX_MS :
                  i_auto_release_ms;

  // Cycles spent low under auto-release; cycles since the last sample start
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || o_irq_out_n || !i_auto_release_en) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
    if (i_rst) begin
      gap_cnt <= 8'hFF;
    end else if (o_sample_start) begin
      gap_cnt <= 8'h00;
    end else if (gap_cnt != 8'hFF) begin
      gap_cnt <= gap_cnt + 8'h01;
    end
  end

  sequence rate_off_s;
    (i_ss_sweep_rate == SS_RATE_OFF) [*3];
  endsequence
  sequence amp_still_s;
    $stable(i_ss_amplitude) [*4];
  endsequence

  a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered next cycle");
  a_rvalid_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd))
    else $error("read valid without a read");
  a_unmapped_zero: assert property (i_reg_rd && i_reg_addr != 8'h02 &&
    i_reg_addr != 8'h03 |=> o_reg_rdata == UNMAPPED_READ_VALUE)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!o_reg_rvalid |-> $stable(o_reg_rdata))
    else $error("read data changed without a read");
  a_irq_held_low: assert property (!i_auto_release_en &&
    !o_irq_out_n && !i_reg_rd |=> !o_irq_out_n)
    else $error("interrupt released without a read");
  a_irq_timeout: assert property
    (low_cnt <= (int'(rel_ms) + 1) * MS_CYCLES + 4)
    else $error("interrupt not released by timeout");
  a_no_irq_asleep: assert property ($fell(o_irq_out_n) |-> !$past(o_sleep))
    else $error("interrupt raised while asleep");
  a_ss_off: assert property
    (rate_off_s |-> !o_ss_active && o_ss_offset == 8'sh00)
    else $error("spread active with sweep rate zero");
  a_ss_bound: assert property (amp_still_s |->
    o_ss_offset <= $signed({2'b00, i_ss_amplitude}) &&
    o_ss_offset >= -$signed({2'b00, i_ss_amplitude}))
    else $error("spread offset beyond amplitude");
  a_sample_gap: assert property (o_sample_start && gap_cnt != 8'hFF
    |-> gap_cnt >= i_sample_cycles)
    else $error("sample started before previous sample ended");
  a_key_steady: assert property (o_sample_start |=> $stable(o_scan_key))
    else $error("scan key changed during a sample");
endmodule : tkec_top_props

bind tkec_top tkec_top_props #(.MS_CYCLES(MS_CYCLES)) u_props (.i_ref_clk,
  .i_rst, .i_reg_rd, .i_reg_addr, .o_reg_rdata, .o_reg_rvalid, .o_irq_out_n,
  .i_auto_release_en, .i_auto_release_ms, .i_ss_sweep_rate, .i_ss_amplitude,
  .o_ss_active, .o_ss_offset, .i_sample_cycles, .o_sample_start, .o_scan_key,
  .o_sleep);

// [dv/tkec_pad_model.sv]
// Sensor pad model answering the scan link of the block
`timescale 1ns/10ps
module tkec_pad_model
  import tkec_pkg::*;
#(
  parameter logic [VAL_W-1:0] BASE  = 16'h0400,
  parameter logic [VAL_W-1:0] TOUCH = 16'h0200
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_sample_start,
  input  wire logic [KEY_W-1:0] i_scan_key,
  input  wire logic [7:0]       i_sample_cycles,
  input  wire logic [15:0]      i_pressed,
  output logic [VAL_W-1:0]      o_raw_value
);
  logic [7:0]       win = 8'h00;
  logic [VAL_W-1:0] level;

  always_ff @(posedge i_ref_clk) begin
    if (i_sample_start) begin
      win <= i_sample_cycles;
    end else if (win != 8'h00) begin
      win <= win - 8'h01;
    end
  end

  assign level = i_pressed[i_scan_key] ? BASE + TOUCH : BASE;
  // Junk outside the sample window
  assign o_raw_value = (i_sample_start || win != 8'h00) ? level : ~level;
endmodule : tkec_pad_model

// [dv/touch_key_event_control_test.sv]
// Self-checking bench of the touch-key event control block
`timescale 1ns/10ps
module touch_key_event_control_test
  import tkec_pkg::*;
;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_reg_rd = 1'b0;
  logic [7:0] i_reg_addr = 8'h00, i_auto_release_ms = 8'h0A;
  logic i_auto_release_en = 1'b0, i_int_mode = 1'b0, i_limit_en = 1'b0;
  logic [15:0] i_first_repeat_ms = 16'h0014, i_repeat_ms = 16'h000A;
  logic [1:0] i_concurrent_key_limit = 2'h1;
  logic [3:0] i_ss_sweep_rate = 4'h0;
  logic [5:0] i_ss_amplitude = 6'h04;
  logic [2:0] i_samples_per_key_log2 = 3'h1;
  logic [7:0] i_sample_cycles = 8'h02, i_round_delay_ms = 8'h01;
  logic i_auto_sleep_en = 1'b0;
  logic [15:0] i_sleep_idle_ms = 16'h0005, i_wake_enable = 16'h0020;
  logic [15:0] pressed = 16'h0000, i_raw_value;
  logic [15:0] neg_th = 16'hFFFF;
  logic [7:0] fr_th = 8'hFF;
  logic [7:0] o_reg_rdata, d;
  logic o_reg_rvalid, o_irq_out_n, o_ss_active, o_sample_start, o_sleep;
  logic signed [7:0] o_ss_offset, peak;
  logic [3:0] o_scan_key;
  int bad_count = 0, checks = 0;
  time t0, t1, t2;

  tkec_top #(.MS_CYCLES(10)) uut (.i_ref_clk, .i_rst, .i_reg_rd, .i_reg_addr,
    .o_reg_rdata, .o_reg_rvalid, .o_irq_out_n, .i_auto_release_en,
    .i_auto_release_ms, .i_int_mode, .i_first_repeat_ms, .i_repeat_ms,
    .i_limit_en, .i_concurrent_key_limit, .i_ss_sweep_rate, .i_ss_amplitude,
    .o_ss_active, .o_ss_offset, .i_recal_cycle_count(8'hFF),
    .i_negative_drift_threshold(neg_th), .i_forced_recal_threshold(fr_th),
    .i_touch_threshold(16'h0100), .i_samples_per_key_log2, .i_sample_cycles,
    .o_sample_start, .o_scan_key, .i_raw_value, .i_round_delay_ms,
    .i_auto_sleep_en, .i_sleep_idle_ms, .i_wake_enable,
    .i_wake_threshold(16'h0100), .o_sleep);
  tkec_pad_model u_pad (.i_ref_clk, .i_sample_start(o_sample_start),
    .i_scan_key(o_scan_key), .i_sample_cycles, .i_pressed(pressed),
    .o_raw_value(i_raw_value));

  always #2 i_ref_clk = ~i_ref_clk;

  task automatic chk(input logic [15:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : cyc

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1;
    chk(o_reg_rvalid, 1'b1, "no read valid");
    q = o_reg_rdata;
  endtask : rd_reg

  task automatic wait_irq(input logic lvl, input int n);
    for (int t = 0; t < n && o_irq_out_n !== lvl; t++) cyc(1);
    chk(o_irq_out_n, lvl, "interrupt level not reached");
  endtask : wait_irq

  task automatic clear_irq();
    rd_reg(8'h02, d);
    rd_reg(8'h03, d);
  endtask : clear_irq

  task automatic press(input logic [15:0] k);
    @(posedge i_ref_clk);
    pressed <= k;
  endtask : press

  task automatic t_spread();
    cyc(5);
    chk({o_ss_active, o_ss_offset}, 9'h000, "spread on at rate zero");
    @(posedge i_ref_clk);
    i_ss_sweep_rate <= 4'h1;
    peak = 8'sh00;
    for (int i = 0; i < 200; i++) begin
      cyc(1);
      if (o_ss_offset > peak) peak = o_ss_offset;
    end
    chk(o_ss_active, 1'b1, "spread not running");
    chk({8'h00, peak}, 16'h0004, "spread peak wrong");
    @(posedge i_ref_clk);
    i_ss_sweep_rate <= 4'h0;
    cyc(5);
    chk(o_ss_offset, 8'h00, "spread not stopped");
  endtask : t_spread

  task automatic t_single();
    press(16'h0008);
    wait_irq(1'b0, 600);
    cyc(300);
    rd_reg(8'h02, d);
    chk(d, 8'h08, "low status wrong");
    chk(o_irq_out_n, 1'b0, "released after one read");
    rd_reg(8'h03, d);
    chk({d, 7'h00, o_irq_out_n}, 16'h0001, "not released by reads");
    cyc(300);
    chk(o_irq_out_n, 1'b1, "repeat in single mode");
    press(16'h0000);
    wait_irq(1'b0, 600);
    rd_reg(8'h02, d);
    chk(d, 8'h00, "release not reported");
    rd_reg(8'h03, d);
  endtask : t_single

  task automatic t_auto();
    @(posedge i_ref_clk);
    i_auto_release_en <= 1'b1;
    press(16'h0200);
    wait_irq(1'b0, 600);
    cyc(80);
    chk(o_irq_out_n, 1'b0, "auto release too early");
    wait_irq(1'b1, 40);
    rd_reg(8'h03, d);
    chk(d, 8'h02, "high status wrong");
    press(16'h0000);
    wait_irq(1'b0, 600);
    wait_irq(1'b1, 120);
    @(posedge i_ref_clk);
    i_auto_release_en <= 1'b0;
  endtask : t_auto

  task automatic t_repeat();
    @(posedge i_ref_clk);
    i_int_mode <= INT_MODE_REPEAT;
    press(16'h0001);
    wait_irq(1'b0, 600);
    t0 = $time;
    clear_irq();
    wait_irq(1'b0, 400);
    t1 = $time;
    clear_irq();
    wait_irq(1'b0, 300);
    t2 = $time;
    chk((t1 - t0) / 4 inside {[185:215]}, 1'b1, "first repeat off");
    chk((t2 - t1) / 4 inside {[85:115]}, 1'b1, "repeat interval off");
    press(16'h0000);
    cyc(300);
    clear_irq();
    cyc(300);
    chk(o_irq_out_n, 1'b1, "repeats after release");
    @(posedge i_ref_clk);
    i_int_mode <= INT_MODE_SINGLE;
  endtask : t_repeat

  task automatic t_limit();
    for (int l = 0; l < 4; l++) begin
      @(posedge i_ref_clk);
      i_limit_en <= (l != 0);
      i_concurrent_key_limit <= 2'(l);
      press(16'h000F);
      cyc(400);
      chk(o_irq_out_n, 1'b0, "no interrupt on press");
      rd_reg(8'h02, d);
      chk(16'($countones(d)), 16'(l == 0 ? 4 : l), "key count");
      rd_reg(8'h03, d);
      press(16'h0000);
      cyc(400);
      clear_irq();
    end
    chk(o_irq_out_n, 1'b1, "interrupt stuck");
  endtask : t_limit

  task automatic t_sleep();
    @(posedge i_ref_clk);
    i_auto_sleep_en <= 1'b1;
    for (int t = 0; t < 600 && o_sleep !== 1'b1; t++) cyc(1);
    chk(o_sleep, 1'b1, "no sleep when idle");
    press(16'h0010);
    cyc(400);
    chk({o_sleep, o_irq_out_n}, 2'h3, "woken by disabled key");
    press(16'h0030);
    for (int t = 0; t < 400 && o_sleep !== 1'b0; t++) cyc(1);
    chk(o_sleep, 1'b0, "enabled key did not wake");
    @(posedge i_ref_clk);
    i_auto_sleep_en <= 1'b0;
    press(16'h0000);
    cyc(400);
    clear_irq();
  endtask : t_sleep

  // Baseline captured while pressed, then drift forces a recalibration
  task automatic t_drift();
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    pressed <= 16'h0004;
    neg_th <= 16'h0100;
    fr_th <= 8'h03;
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    cyc(1);
    chk({o_irq_out_n, o_sleep, o_reg_rvalid}, 3'h4, "reset state");
    cyc(150);
    press(16'h0000);
    cyc(500);
    press(16'h0004);
    wait_irq(1'b0, 300);
    rd_reg(8'h02, d);
    chk(d, 8'h04, "forced recalibration missing");
    rd_reg(8'h03, d);
    press(16'h0000);
    cyc(300);
    clear_irq();
  endtask : t_drift

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    #120000;
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    cyc(1);
    chk({o_irq_out_n, o_sleep, o_reg_rvalid}, 3'h4, "reset state");
    rd_reg(8'h40, d);
    chk(d, 8'h00, "unmapped read");
    t_spread();
    t_single();
    t_auto();
    t_repeat();
    t_limit();
    t_sleep();
    t_drift();
    tally_and_finish();
  end
endmodule : touch_key_event_control_test
